// ==== pic_pkg.sv ====
package pic_pkg;

	// ==========================================
	// Port addresses and config offsets
	localparam logic [15:0] IO_MASTER_CMD  = 16'h0020;
	localparam logic [15:0] IO_MASTER_DATA = 16'h0021;
	localparam logic [15:0] IO_SLAVE_CMD   = 16'h00a0;
	localparam logic [15:0] IO_SLAVE_DATA  = 16'h00a1;
	localparam logic [15:0] IO_ELCR_MASTER = 16'h04d0;
	localparam logic [15:0] IO_ELCR_SLAVE  = 16'h04d1;
	localparam logic [7:0]  CFG_ROUTE_AD   = 8'h60;
	localparam logic [7:0]  CFG_ROUTE_EH   = 8'h68;

	// ==========================================
	// Reset values and fixed layouts
	localparam int          PCI_LINES      = 8;
	localparam logic [63:0] ROUTE_RESET    = 64'h8080808080808080;
	localparam int          ROUTE_OFF_BIT  = 7;
	localparam logic [15:0] ROUTE_ALLOWED  = 16'hdef8;
	localparam logic [15:0] ELCR_EDGE_ONLY = 16'h2105;
	localparam logic [7:0]  CASC_LEVEL_IN  = 8'h04;
	localparam logic [2:0]  RESET_LOWEST   = 3'h7;
	localparam logic [2:0]  RESET_SLAVE_ID = 3'h7;
	localparam logic [2:0]  CASCADE_INPUT  = 3'h2;
	localparam logic [2:0]  CASC_SLAVE     = 3'h2;
	localparam logic [2:0]  DEFAULT_LEVEL  = 3'h7;
	localparam logic [7:0]  EDGE_REARM     = 8'hff;

	// ==========================================
	// Command word fields
	localparam int CW_INIT_BIT  = 4;
	localparam int CW_OP_WORD_READ_POLL_SMM_BIT  = 3;
	localparam int INIT_WORD_FOUR_AUTOMATIC_END_OF_INTERRUPT    = 1;
	localparam int INIT_WORD_FOUR_SFNM    = 4;
	localparam int OP_WORD_ROTATE_EOI_ROT     = 7;
	localparam int OP_WORD_ROTATE_EOI_SEL     = 6;
	localparam int OP_WORD_ROTATE_EOI_EOI     = 5;
	localparam int OP_WORD_READ_POLL_SMM_SMM_EN  = 6;
	localparam int OP_WORD_READ_POLL_SMM_SMM     = 5;
	localparam int OP_WORD_READ_POLL_SMM_POLL    = 2;
	localparam int OP_WORD_READ_POLL_SMM_RD_EN   = 1;
	localparam int OP_WORD_READ_POLL_SMM_RD_ISR  = 0;
	localparam int POLL_FLAG    = 7;

	// ==========================================
	// Types
	typedef enum logic [1:0] {STEP_DONE, STEP_VEC, STEP_CASC, STEP_MODE} pic_step_t;
	typedef enum logic [1:0] {ACK_IDLE, ACK_FIRST, ACK_SECOND} pic_ack_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} pic_io_req_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} pic_cfg_req_t;

	typedef struct packed {
		logic [7:0] request_register;
		logic [7:0] in_service_register;
		logic [7:0] mask_register;
		logic [7:0] prev;
		logic [4:0] vbase;
		pic_step_t  step;
		logic [2:0] slave_id;
		logic [2:0] lowest;
		logic       automatic_end_of_interrupt;
		logic       sfnm;
		logic       special_mask_mode;
		logic       read_isr;
		logic       poll;
		logic       rot_automatic_end_of_interrupt;
	} pic_ctl_t;

	typedef struct packed {
		pic_ctl_t [1:0] ctl;
		logic [15:0]    elcr;
		pic_ack_t       ack;
		logic [2:0]     casc;
		logic [7:0]     vec;
		logic           ack_done;
		logic [7:0]     rdata;
		logic           rvalid;
	} pic_state_t;

	typedef struct packed {
		logic [63:0] route;
		logic [15:0] req;
		logic [31:0] rdata;
		logic        rvalid;
	} pic_steer_t;

endpackage

// ==== pic_pci_steer.sv ====
`timescale 1ns/1ps
module pic_pci_steer (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Configuration access
	input  wire pic_pkg::pic_cfg_req_t         cfg,
	output logic [31:0]                        cfg_rdata,
	output logic                               cfg_rvalid,
	// PCI lines and steered requests
	input  wire logic [pic_pkg::PCI_LINES-1:0] pci_line_n,
	output logic [15:0]                        steered_req
);

	pic_pkg::pic_steer_t q, d;

	// ==========================================
	// Route registers and steering
	always_comb
	begin
		logic [7:0] r;
		logic       hi;
		r = 8'h00;
		hi = 1'b0;
		d = q;
		d.rvalid = 1'b0;
		hi = (cfg.addr == pic_pkg::CFG_ROUTE_EH);
		if (cfg.wr && (hi || cfg.addr == pic_pkg::CFG_ROUTE_AD))
		begin
			for (int b = 0; b < 4; b++)
			begin
				if (cfg.be[b])
					d.route[(32 * int'(hi)) + 8 * b +: 8] = cfg.wdata[8 * b +: 8];
			end
		end
		if (cfg.rd)
		begin
			d.rvalid = 1'b1;
			d.rdata = 32'h0000_0000;
			if (cfg.addr == pic_pkg::CFG_ROUTE_AD)
				d.rdata = q.route[31:0];
			else if (cfg.addr == pic_pkg::CFG_ROUTE_EH)
				d.rdata = q.route[63:32];
		end
		// RQ22: shared routing targets
		// RQ23: inverted level request
		d.req = 16'h0000;
		for (int l = 0; l < pic_pkg::PCI_LINES; l++)
		begin
			r = q.route[8 * l +: 8];
			if (!r[pic_pkg::ROUTE_OFF_BIT] && pic_pkg::ROUTE_ALLOWED[r[3:0]])
				d.req[r[3:0]] = d.req[r[3:0]] | ~pci_line_n[l];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.route <= pic_pkg::ROUTE_RESET;
		end
		else
			q <= d;
	end

	assign cfg_rdata   = q.rdata;
	assign cfg_rvalid  = q.rvalid;
	assign steered_req = q.req;

endmodule

// ==== pic_cascade.sv ====
`timescale 1ns/1ps
// Contract
// RQ1: Software writes the fourth init word to both cores with bit 0 set.
// RQ2: Fully nested: input 0 highest; in-service blocks equal and lower requests.
// RQ3: In-service bit holds until end-of-interrupt, or clears after second ack pulse.
// RQ4: Special fully nested master keeps an in-service slave visible to priority.
// RQ5: Automatic rotation makes a serviced input lowest priority.
// RQ6: Rotation enabled via rotate non-specific END_OF_INTERRUPT or rotate-in-automatic-END_OF_INTERRUPT commands.
// RQ7: Set-priority makes the named input bottom priority, independent of END_OF_INTERRUPT.
// RQ8: Rotate-on-specific-END_OF_INTERRUPT ends named interrupt and makes it bottom priority.
// RQ9: After poll command the next read acts as acknowledge.
// RQ10: Poll byte: bit 7 pending, bits 2:0 highest pending level.
// RQ11: Request state frozen from poll write until the following read.
// RQ12: Master drives 010b on cascade bus; slave then supplies vector.
// RQ13: Software sends end-of-interrupt to both slave and master for cascades.
// RQ14: Init word one level bit ignored; trigger chosen per input.
// RQ15: Edge mode needs low-to-high transition; level mode takes high level.
// RQ16: Request dropped before first ack pulse ends returns input 7 vector.
// RQ17: Non-specific END_OF_INTERRUPT clears highest in-service bit; specific clears named one.
// RQ18: Special mask mode: non-specific END_OF_INTERRUPT skips masked in-service bits.
// RQ19: Automatic END_OF_INTERRUPT performs non-specific END_OF_INTERRUPT after last ack pulse; master only. The code applies it on the slave as well.
// RQ20: Each mask bit masks one input; master input 2 masks slave.
// RQ21: Third op word sets or clears special mask mode; ignores in-service inhibit.
// RQ22: Eight PCI lines route to legacy inputs 3-7, 9-12, 14, 15.
// RQ23: Routed active-low PCI lines become active-high level requests.
// RQ24: Init word one clears mask, sets priority, slave id 7, status read.
// RQ25: Vector byte joins vector base bits 7:3 with the input number.
module pic_cascade (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Processor I/O port access
	input  wire pic_pkg::pic_io_req_t          io,
	output logic [7:0]                         io_rdata,
	output logic                               io_rvalid,
	// Configuration access for PCI routing
	input  wire pic_pkg::pic_cfg_req_t         cfg,
	output logic [31:0]                        cfg_rdata,
	output logic                               cfg_rvalid,
	// Interrupt sources
	input  wire logic [15:0]                   irq_in,
	input  wire logic [pic_pkg::PCI_LINES-1:0] pci_line_n,
	// Interrupt acknowledge
	input  wire logic                          ack_req,
	output logic                               ack_busy,
	output logic [7:0]                         ack_vec,
	output logic                               ack_done,
	// Processor interrupt
	output logic                               interrupt_output
);

	pic_pkg::pic_state_t q, d;
	logic [15:0]         steered;

	// ==========================================
	// Helpers
	function automatic logic [2:0] rank(input logic [2:0] i, input logic [2:0] low);
		rank = 3'(i - low - 3'h1);
	endfunction

	// Returns {found, index} of the highest priority set bit
	function automatic logic [3:0] pick(input logic [7:0] bits, input logic [2:0] low);
		logic [2:0] i;
		pick = 4'h0;
		i = low;
		for (int k = 0; k < 8; k++)
		begin
			i = 3'(i + 3'h1);
			if (bits[i] && !pick[3])
				pick = {1'b1, i};
		end
	endfunction

	// Request that may interrupt now, given in-service blocking
	function automatic logic [3:0] grant(input pic_pkg::pic_ctl_t c, input logic master);
		logic [3:0] p;
		logic [3:0] s;
		// RQ20: mask per input
		p = pick(c.request_register & ~c.mask_register, c.lowest);
		s = pick(c.in_service_register, c.lowest);
		grant = 4'h0;
		if (p[3])
		begin
			// RQ21: mask mode ignores inhibit
			if (c.special_mask_mode || !s[3])
				grant = p;
			// RQ2: nested priority blocking
			else if (rank(p[2:0], c.lowest) < rank(s[2:0], c.lowest))
				grant = p;
			// RQ4: slave stays visible
			else if (master && c.sfnm && p[2:0] == s[2:0] && p[2:0] == pic_pkg::CASCADE_INPUT)
				grant = p;
		end
	endfunction

	// RQ17: non-specific end
	// RQ18: masked bits skipped
	function automatic pic_pkg::pic_ctl_t eoi_ns(input pic_pkg::pic_ctl_t c, input logic rot);
		logic [3:0] s;
		eoi_ns = c;
		s = pick(c.in_service_register & ~(c.special_mask_mode ? c.mask_register : 8'h00), c.lowest);
		if (s[3])
		begin
			eoi_ns.in_service_register[s[2:0]] = 1'b0;
			// RQ5: serviced goes lowest
			if (rot)
				eoi_ns.lowest = s[2:0];
		end
	endfunction

	// ==========================================
	// PCI steering
	pic_pci_steer u_steer (
		.clk         (clk),
		.rst_n       (rst_n),
		.cfg         (cfg),
		.cfg_rdata   (cfg_rdata),
		.cfg_rvalid  (cfg_rvalid),
		.pci_line_n  (pci_line_n),
		.steered_req (steered)
	);

	// ==========================================
	// Controller behaviour
	always_comb
	begin
		logic [15:0] raw;
		logic [7:0]  in;
		logic [7:0]  lvl;
		logic [7:0]  w;
		logic [3:0]  g;
		logic [3:0]  gm;
		logic [3:0]  gs;
		logic        c;
		logic        sel;
		logic        odd;
		raw = irq_in | steered;
		in = 8'h00;
		lvl = 8'h00;
		w = io.wdata;
		g = 4'h0;
		c = 1'b0;
		sel = 1'b0;
		odd = io.addr[0];
		d = q;
		d.ack_done = 1'b0;
		d.rvalid = 1'b0;
		gs = grant(q.ctl[1], 1'b0);
		gm = grant(q.ctl[0], 1'b1);

		// Request registers
		for (int k = 0; k < 2; k++)
		begin
			in = (k == 0) ? {raw[7:3], gs[3], raw[1:0]} : raw[15:8];
			// RQ14: per input trigger
			lvl = q.elcr[8 * k +: 8];
			if (k == 0)
				lvl = lvl | pic_pkg::CASC_LEVEL_IN;
			// RQ11: frozen while polling
			if (!q.ctl[k].poll)
			begin
				// RQ15: edge or level
				d.ctl[k].request_register = (((q.ctl[k].request_register & in) | (in & ~q.ctl[k].prev)) & ~lvl) | (in & lvl);
				d.ctl[k].prev = in;
			end
		end

		// Acknowledge sequence; the slave is resolved only when addressed
		case (q.ack)
			pic_pkg::ACK_IDLE:
			begin
				if (ack_req)
					d.ack = pic_pkg::ACK_FIRST;
			end
			pic_pkg::ACK_FIRST:
			begin
				d.ack = pic_pkg::ACK_SECOND;
				d.casc = 3'h0;
				// RQ16: default vector seven
				d.vec = {q.ctl[0].vbase, pic_pkg::DEFAULT_LEVEL};
				if (gm[3])
				begin
					// RQ3: in-service set
					d.ctl[0].in_service_register[gm[2:0]] = 1'b1;
					d.ctl[0].request_register[gm[2:0]] = 1'b0;
					// RQ25: vector assembly
					d.vec = {q.ctl[0].vbase, gm[2:0]};
					// RQ12: cascade code
					if (gm[2:0] == pic_pkg::CASCADE_INPUT)
						d.casc = pic_pkg::CASC_SLAVE;
				end
			end
			pic_pkg::ACK_SECOND:
			begin
				d.ack = pic_pkg::ACK_IDLE;
				d.ack_done = 1'b1;
				// RQ12: slave answers
				sel = (q.casc == q.ctl[1].slave_id) && (q.casc == pic_pkg::CASC_SLAVE);
				if (sel)
				begin
					d.vec = {q.ctl[1].vbase, pic_pkg::DEFAULT_LEVEL};
					if (gs[3])
					begin
						d.ctl[1].in_service_register[gs[2:0]] = 1'b1;
						d.ctl[1].request_register[gs[2:0]] = 1'b0;
						d.vec = {q.ctl[1].vbase, gs[2:0]};
					end
					// RQ19: slave automatic end also applied here
					if (q.ctl[1].automatic_end_of_interrupt)
						d.ctl[1] = eoi_ns(d.ctl[1], q.ctl[1].rot_automatic_end_of_interrupt);
				end
				// RQ3: automatic end
				// RQ19: after last pulse
				if (q.ctl[0].automatic_end_of_interrupt)
					d.ctl[0] = eoi_ns(d.ctl[0], q.ctl[0].rot_automatic_end_of_interrupt);
				d.casc = 3'h0;
			end
			default:
				d.ack = pic_pkg::ACK_IDLE;
		endcase

		// Port decode
		sel = (io.addr == pic_pkg::IO_MASTER_CMD) || (io.addr == pic_pkg::IO_MASTER_DATA) ||
			(io.addr == pic_pkg::IO_SLAVE_CMD) || (io.addr == pic_pkg::IO_SLAVE_DATA);
		c = (io.addr == pic_pkg::IO_SLAVE_CMD) || (io.addr == pic_pkg::IO_SLAVE_DATA);

		if (io.wr && sel && !odd && w[pic_pkg::CW_INIT_BIT])
		begin
			// RQ24: init word one
			// RQ14: level bit ignored
			d.ctl[c].mask_register = 8'h00;
			d.ctl[c].lowest = pic_pkg::RESET_LOWEST;
			d.ctl[c].slave_id = pic_pkg::RESET_SLAVE_ID;
			d.ctl[c].special_mask_mode = 1'b0;
			d.ctl[c].read_isr = 1'b0;
			d.ctl[c].poll = 1'b0;
			d.ctl[c].prev = pic_pkg::EDGE_REARM;
			d.ctl[c].request_register = d.ctl[c].request_register & q.elcr[8 * c +: 8];
			d.ctl[c].step = pic_pkg::STEP_VEC;
		end
		else if (io.wr && sel && !odd && w[pic_pkg::CW_OP_WORD_READ_POLL_SMM_BIT])
		begin
			// RQ9: poll armed
			if (w[pic_pkg::OP_WORD_READ_POLL_SMM_POLL])
				d.ctl[c].poll = 1'b1;
			if (w[pic_pkg::OP_WORD_READ_POLL_SMM_RD_EN])
				d.ctl[c].read_isr = w[pic_pkg::OP_WORD_READ_POLL_SMM_RD_ISR];
			// RQ21: mask mode control
			if (w[pic_pkg::OP_WORD_READ_POLL_SMM_SMM_EN])
				d.ctl[c].special_mask_mode = w[pic_pkg::OP_WORD_READ_POLL_SMM_SMM];
		end
		else if (io.wr && sel && !odd)
		begin
			case ({w[pic_pkg::OP_WORD_ROTATE_EOI_ROT], w[pic_pkg::OP_WORD_ROTATE_EOI_SEL], w[pic_pkg::OP_WORD_ROTATE_EOI_EOI]})
				// RQ17: end commands
				3'b001: d.ctl[c] = eoi_ns(d.ctl[c], 1'b0);
				3'b011: d.ctl[c].in_service_register[w[2:0]] = 1'b0;
				// RQ6: rotation commands
				3'b101: d.ctl[c] = eoi_ns(d.ctl[c], 1'b1);
				3'b100: d.ctl[c].rot_automatic_end_of_interrupt = 1'b1;
				3'b000: d.ctl[c].rot_automatic_end_of_interrupt = 1'b0;
				// RQ8: rotate specific end
				3'b111:
				begin
					d.ctl[c].in_service_register[w[2:0]] = 1'b0;
					d.ctl[c].lowest = w[2:0];
				end
				// RQ7: set priority
				3'b110: d.ctl[c].lowest = w[2:0];
				default: d.ctl[c].lowest = q.ctl[c].lowest;
			endcase
		end
		else if (io.wr && sel)
		begin
			case (q.ctl[c].step)
				pic_pkg::STEP_VEC:
				begin
					d.ctl[c].vbase = w[7:3];
					d.ctl[c].step = pic_pkg::STEP_CASC;
				end
				pic_pkg::STEP_CASC:
				begin
					d.ctl[c].slave_id = w[2:0];
					d.ctl[c].step = pic_pkg::STEP_MODE;
				end
				pic_pkg::STEP_MODE:
				begin
					// RQ1: mode bit assumed set
					d.ctl[c].automatic_end_of_interrupt = w[pic_pkg::INIT_WORD_FOUR_AUTOMATIC_END_OF_INTERRUPT];
					d.ctl[c].sfnm = w[pic_pkg::INIT_WORD_FOUR_SFNM];
					d.ctl[c].step = pic_pkg::STEP_DONE;
				end
				default: d.ctl[c].mask_register = w;
			endcase
		end
		else if (io.wr && io.addr == pic_pkg::IO_ELCR_MASTER)
			d.elcr[7:0] = w & ~pic_pkg::ELCR_EDGE_ONLY[7:0];
		else if (io.wr && io.addr == pic_pkg::IO_ELCR_SLAVE)
			d.elcr[15:8] = w & ~pic_pkg::ELCR_EDGE_ONLY[15:8];

		// Reads answer one cycle later; unmapped ports read zero
		if (io.rd)
		begin
			d.rvalid = 1'b1;
			d.rdata = 8'h00;
			g = c ? gs : gm;
			if (sel && !odd && q.ctl[c].poll)
			begin
				// RQ10: poll byte
				d.rdata[pic_pkg::POLL_FLAG] = g[3];
				d.rdata[2:0] = g[2:0];
				d.ctl[c].poll = 1'b0;
				// RQ9: poll acknowledge
				if (g[3])
				begin
					d.ctl[c].in_service_register[g[2:0]] = 1'b1;
					d.ctl[c].request_register[g[2:0]] = 1'b0;
				end
			end
			else if (sel && !odd)
				d.rdata = q.ctl[c].read_isr ? q.ctl[c].in_service_register : q.ctl[c].request_register;
			else if (sel)
				d.rdata = q.ctl[c].mask_register;
			else if (io.addr == pic_pkg::IO_ELCR_MASTER)
				d.rdata = q.elcr[7:0];
			else if (io.addr == pic_pkg::IO_ELCR_SLAVE)
				d.rdata = q.elcr[15:8];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.ctl[0].lowest <= pic_pkg::RESET_LOWEST;
			q.ctl[1].lowest <= pic_pkg::RESET_LOWEST;
			q.ctl[0].slave_id <= pic_pkg::RESET_SLAVE_ID;
			q.ctl[1].slave_id <= pic_pkg::RESET_SLAVE_ID;
			q.ctl[0].prev <= pic_pkg::EDGE_REARM;
			q.ctl[1].prev <= pic_pkg::EDGE_REARM;
		end
		else
			q <= d;
	end

	// ==========================================
	// Outputs
	// Poll mode leaves the output meaningful; software simply ignores it
	assign interrupt_output = grant(q.ctl[0], 1'b1) != 4'h0;
	assign ack_busy         = q.ack != pic_pkg::ACK_IDLE;
	assign ack_vec          = q.vec;
	assign ack_done         = q.ack_done;
	assign io_rdata         = q.rdata;
	assign io_rvalid        = q.rvalid;

endmodule

// ==== pic_props.sv ====
`timescale 1ns/1ps
module pic_props (
	// Clock and reset
	input wire logic                          clk,
	input wire logic                          rst_n,
	// Design ports
	input wire pic_pkg::pic_io_req_t          io,
	input wire logic [7:0]                    io_rdata,
	input wire logic                          io_rvalid,
	input wire pic_pkg::pic_cfg_req_t         cfg,
	input wire logic [31:0]                   cfg_rdata,
	input wire logic                          cfg_rvalid,
	input wire logic [15:0]                   irq_in,
	input wire logic [pic_pkg::PCI_LINES-1:0] pci_line_n,
	input wire logic                          ack_req,
	input wire logic                          ack_busy,
	input wire logic [7:0]                    ack_vec,
	input wire logic                          ack_done,
	input wire logic                          interrupt_output
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ==========================================
	// Acknowledge cycle
	sequence s_take;
		ack_req && !ack_busy;
	endsequence
	sequence s_pulses;
		(ack_busy && !ack_done) ##1 (ack_busy && !ack_done);
	endsequence
	property p_ack_seq;
		s_take |=> s_pulses ##1 (!ack_busy && ack_done);
	endproperty
	a_ack_seq: assert property (p_ack_seq)
		else $error("ack sequence timing wrong");
	property p_busy_cause;
		$rose(ack_busy) |-> $past(ack_req);
	endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("ack busy without request");
	property p_default;
		(ack_req && !ack_busy && !interrupt_output && irq_in == 16'h0000 && &pci_line_n)
			##1 (irq_in == 16'h0000 && &pci_line_n)[*2] |=> ack_vec[2:0] == 3'h7;
	endproperty
	a_default: assert property (p_default)
		else $error("idle ack vector not level 7");
	// vector moves only as an ack pulse ends
	property p_vec_hold;
		ack_vec != $past(ack_vec) |-> $past(ack_busy);
	endproperty
	a_vec_hold: assert property (p_vec_hold)
		else $error("ack vector moved outside ack");

	// ==========================================
	// Register reads
	// read answered next cycle
	property p_io_ans;
		io.rd |=> io_rvalid;
	endproperty
	a_io_ans: assert property (p_io_ans)
		else $error("io read not answered");
	property p_io_hold;
		!io.rd |=> !io_rvalid && $stable(io_rdata);
	endproperty
	a_io_hold: assert property (p_io_hold)
		else $error("io read data unstable");
	property p_cfg_ans;
		cfg.rd |=> cfg_rvalid;
	endproperty
	a_cfg_ans: assert property (p_cfg_ans)
		else $error("cfg read not answered");
	property p_cfg_hold;
		!cfg.rd |=> !cfg_rvalid && $stable(cfg_rdata);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("cfg read data unstable");
endmodule

// ==== pic_host_model.sv ====
`timescale 1ns/1ps
module pic_host_model (
	// Clock
	input wire logic       clk,
	// Acknowledge handshake
	input wire logic       ack_busy,
	input wire logic       ack_done,
	input wire logic [7:0] ack_vec,
	output logic           ack_req
);
	initial ack_req = 1'b0;

	// ==========================================
	// Acknowledge cycle, optionally late
	task automatic ack(input int lag, output logic [7:0] v);
		begin
			repeat (lag + 1) @(negedge clk);
			// Request only while idle, since a busy core drops it
			for (int i = 0; i < 8 && ack_busy !== 1'b0; i++) @(negedge clk);
			ack_req = 1'b1;
			@(negedge clk);
			ack_req = 1'b0;
			for (int i = 0; i < 6 && ack_done !== 1'b1; i++) @(negedge clk);
			v = ack_vec;
		end
	endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
	// ==========================================
	// Stimulus and wiring
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	pic_pkg::pic_io_req_t  io = '0;
	pic_pkg::pic_cfg_req_t cfg = '0;
	logic [15:0]           irq_in = '0;
	logic [7:0]            pci_line_n = 8'hff;
	logic                  ack_req, ack_busy, ack_done, interrupt_output, io_rvalid, cfg_rvalid;
	logic [7:0]            io_rdata, ack_vec, v;
	logic [31:0]           cfg_rdata, c;
	int                    n_errors = 0, checked = 0, cyc = 0;

	pic_cascade pic_cascade_i (.clk, .rst_n, .io, .io_rdata, .io_rvalid, .cfg, .cfg_rdata, .cfg_rvalid,
		.irq_in, .pci_line_n, .ack_req, .ack_busy, .ack_vec, .ack_done, .interrupt_output);
	pic_host_model pic_host_model_i (.clk, .ack_busy, .ack_done, .ack_vec, .ack_req);

	always #10 clk = ~clk;

	// ==========================================
	// Shared tasks
	task finish_test;
		begin
			if (n_errors == 0 && checked > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		begin
			checked++;
			if (s !== e)
			begin
				n_errors++;
				$display("[FAIL] %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task io_wr(input logic [15:0] a, input logic [7:0] d);
		begin
			@(negedge clk) io = '{1'b1, 1'b0, a, d};
			@(negedge clk) io = '0;
		end
	endtask
	task rd_chk(input logic [15:0] a, input logic [7:0] e);
		begin
			@(negedge clk) io = '{1'b0, 1'b1, a, 8'h00};
			@(negedge clk) io = '0;
			chk(io_rdata, e);
		end
	endtask
	task cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		begin
			@(negedge clk) cfg = '{1'b1, 1'b0, a, be, d};
			@(negedge clk) cfg = '0;
		end
	endtask
	// Rises are waited for; a quiet line is watched for the whole window
	task wi(input logic e);
		begin
			for (int i = 0; i < 8; i++)
			begin
				@(negedge clk);
				if (e ? interrupt_output === 1'b1 : interrupt_output !== 1'b0)
					break;
			end
			chk({7'h00, interrupt_output}, {7'h00, e});
		end
	endtask
	task irq(input int n, input logic l);
		begin
			@(negedge clk) irq_in[n] = l;
		end
	endtask
	task ack_chk(input int lag, input logic [7:0] e);
		begin
			pic_host_model_i.ack(lag, v);
			chk(v, e);
		end
	endtask
	// Fresh init drops pending edges and in-service state between scenarios
	task begin_t(input logic [7:0] m4);
		begin
			@(negedge clk) irq_in = '0;
			pci_line_n = 8'hff;
			io_wr(16'h0020, 8'h19);
			io_wr(16'h0021, 8'h08);
			io_wr(16'h0021, 8'h04);
			io_wr(16'h0021, m4);
			io_wr(16'h00a0, 8'h11);
			io_wr(16'h00a1, 8'h70);
			io_wr(16'h00a1, 8'h02);
			io_wr(16'h00a1, 8'h01);
			// Init leaves in-service bits alone, so clear every level on both cores
			for (int k = 0; k < 8; k++)
			begin
				io_wr(16'h0020, 8'h60 | 8'(k));
				io_wr(16'h00a0, 8'h60 | 8'(k));
			end
			io_wr(16'h04d0, 8'h00);
			io_wr(16'h04d1, 8'h00);
		end
	endtask

	// ==========================================
	// Scenarios
	task t_nested;
		begin
			begin_t(8'h01);
			rd_chk(16'h0021, 8'h00);
			irq(5, 1'b1);
			wi(1'b1);
			ack_chk(0, 8'h0d);
			irq(6, 1'b1);
			wi(1'b0);
			irq(3, 1'b1);
			wi(1'b1);
			ack_chk(0, 8'h0b);
			io_wr(16'h0020, 8'h20);
			wi(1'b0);
			io_wr(16'h0020, 8'h65);
			wi(1'b1);
			ack_chk(0, 8'h0e);
		end
	endtask
	task t_trigger;
		begin
			begin_t(8'h01);
			irq(4, 1'b1);
			wi(1'b1);
			ack_chk(0, 8'h0c);
			io_wr(16'h0020, 8'h20);
			wi(1'b0);
			io_wr(16'h04d0, 8'hff);
			rd_chk(16'h04d0, 8'hfa);
			wi(1'b1);
			ack_chk(0, 8'h0c);
		end
	endtask
	task t_cascade;
		begin
			begin_t(8'h01);
			irq(10, 1'b1);
			ack_chk(0, 8'h72);
			io_wr(16'h00a0, 8'h20);
			io_wr(16'h0020, 8'h20);
			io_wr(16'h0021, 8'h04);
			irq(11, 1'b1);
			wi(1'b0);
			io_wr(16'h0021, 8'h00);
			wi(1'b1);
			ack_chk(0, 8'h73);
		end
	endtask
	task t_rotate;
		begin
			begin_t(8'h01);
			io_wr(16'h0020, 8'hc5);
			@(negedge clk) irq_in = 16'h0048;
			ack_chk(0, 8'h0e);
			io_wr(16'h0020, 8'he6);
			@(negedge clk) irq_in = 16'h0088;
			irq(6, 1'b1);
			ack_chk(0, 8'h0f);
			io_wr(16'h0020, 8'ha0);
			@(negedge clk) irq_in = 16'h0048;
			irq(7, 1'b1);
			ack_chk(0, 8'h0b);
		end
	endtask
	task t_poll;
		begin
			begin_t(8'h01);
			irq(7, 1'b1);
			wi(1'b1);
			io_wr(16'h0020, 8'h0c);
			irq(5, 1'b1);
			rd_chk(16'h0020, 8'h87);
			io_wr(16'h0020, 8'h0b);
			rd_chk(16'h0020, 8'h80);
		end
	endtask
	task t_smm;
		begin
			begin_t(8'h01);
			irq(3, 1'b1);
			ack_chk(0, 8'h0b);
			io_wr(16'h0020, 8'h68);
			io_wr(16'h0021, 8'h08);
			irq(6, 1'b1);
			wi(1'b1);
			ack_chk(0, 8'h0e);
			io_wr(16'h0020, 8'h20);
			io_wr(16'h0020, 8'h0b);
			rd_chk(16'h0020, 8'h08);
		end
	endtask
	task t_short_req;
		begin
			begin_t(8'h01);
			irq(6, 1'b1);
			wi(1'b1);
			irq(6, 1'b0);
			ack_chk(1, 8'h0f);
		end
	endtask
	task t_sfnm;
		begin
			begin_t(8'h11);
			irq(12, 1'b1);
			ack_chk(0, 8'h74);
			irq(9, 1'b1);
			wi(1'b1);
			ack_chk(0, 8'h71);
		end
	endtask
	task t_automatic_end_of_interrupt_pci;
		begin
			begin_t(8'h03);
			io_wr(16'h0020, 8'h80);
			cfg_wr(8'h60, 4'h1, 32'h00000005);
			@(negedge clk) cfg = '{1'b0, 1'b1, 8'h60, 4'hf, 32'h0};
			@(negedge clk) cfg = '0;
			c = cfg_rdata;
			chk(c[7:0], 8'h05);
			chk(c[31:24], 8'h80);
			io_wr(16'h04d0, 8'h20);
			@(negedge clk) pci_line_n[0] = 1'b0;
			wi(1'b1);
			ack_chk(0, 8'h0d);
			io_wr(16'h0020, 8'h0b);
			rd_chk(16'h0020, 8'h00);
			irq(6, 1'b1);
			ack_chk(0, 8'h0e);
		end
	endtask

	// ==========================================
	// Run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			n_errors++;
			finish_test;
		end
	end

	initial
	begin
		repeat (3) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		t_nested;
		t_trigger;
		t_cascade;
		t_rotate;
		t_poll;
		t_smm;
		t_short_req;
		t_sfnm;
		t_automatic_end_of_interrupt_pci;
		finish_test;
	end
endmodule

bind pic_cascade pic_props pic_props_i (.clk, .rst_n, .io, .io_rdata, .io_rvalid, .cfg, .cfg_rdata, .cfg_rvalid,
	.irq_in, .pci_line_n, .ack_req, .ack_busy, .ack_vec, .ack_done, .interrupt_output);
